// ==== design/aup_bclk_frame_gen.sv ====
// apb register file and three audio port clock generators
`timescale 1ns/1ps
module aup_bclk_frame_gen (
    input wire logic clk_sys, // system clock, 100 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [15:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    output logic [2:0] bclk, // bit clock per port
    output logic [2:0] lrclk, // frame clock per port
    output logic [2:0] clk_oe // clocks driven (master) per port
);
    localparam int NP = aup_pkg::NPORT;

    // decode of the current transfer
    logic [aup_pkg::IDXW-1:0] idx;
    logic wr_go;
    logic fam_hit;
    logic any_hit;
    logic [NP-1:0] ctrl_hit;
    logic [NP-1:0] div_hit;
    logic [NP-1:0] mode_hit;
    logic [NP-1:0] ctrl_wr;
    logic [NP-1:0] div_wr;
    logic [NP-1:0] mode_wr;
    // per-port status and read words gathered from the port blocks
    logic [NP-1:0] use_async;
    logic [NP-1:0] use_44k;
    logic [NP-1:0] master_q;
    logic [31:0] port_word [NP];
    logic [31:0] rd_word;
    // shared family bits and the apb response
    logic [1:0] fam_reg;
    logic [1:0] fam_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic ready_reg;
    logic ready_next;
    logic err_reg;
    logic err_next;

    // paddr[1:0] are ignored: every register is one aligned word
    assign idx = paddr[15:2];
    // a write lands only at the edge that completes the access phase
    assign wr_go = psel && penable && ready_reg && pwrite;
    assign fam_hit = (idx == aup_pkg::IDX_FAMILY);
    assign any_hit = fam_hit || (|ctrl_hit) || (|div_hit) || (|mode_hit);

    for (genvar p = 0; p < NP; p++) begin : g_port
        logic [4:0] freq_reg;
        logic [4:0] freq_next;
        logic [12:0] bcpf_reg;
        logic [12:0] bcpf_next;
        logic [3:0] rate_reg;
        logic [3:0] rate_next;
        logic master_reg;
        logic master_next;
        logic [31:0] word;

        assign ctrl_hit[p] = (idx == aup_pkg::IDX_CTRL[p]);
        assign div_hit[p] = (idx == aup_pkg::IDX_DIV[p]);
        assign mode_hit[p] = (idx == aup_pkg::IDX_MODE[p]);
        assign ctrl_wr[p] = wr_go && ctrl_hit[p];
        assign div_wr[p] = wr_go && div_hit[p];
        assign mode_wr[p] = wr_go && mode_hit[p];

        assign use_async[p] = (rate_reg >= aup_pkg::RATE_ASYNC_MIN);
        // the domain only picks the family bit; both domains run on clk_sys here
        assign use_44k[p] = use_async[p] ? fam_reg[aup_pkg::FAM_ASYNC_BIT]
                                         : fam_reg[aup_pkg::FAM_SYS_BIT];

        always_comb begin
            freq_next = freq_reg;
            bcpf_next = bcpf_reg;
            rate_next = rate_reg;
            master_next = master_reg;
            if (ctrl_wr[p]) begin
                freq_next = pwdata[4:0];
            end
            // no clamp: a divisor below 8 still counts, keeping it in range is up to software
            if (div_wr[p]) begin
                bcpf_next = pwdata[12:0];
            end
            // the status bits of the mode word are read-only and ignore writes
            if (mode_wr[p]) begin
                rate_next = pwdata[3:0];
                master_next = pwdata[aup_pkg::MODE_MASTER_BIT];
            end
        end

        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                freq_reg <= aup_pkg::FREQ_RST;
                bcpf_reg <= aup_pkg::BCPF_RST;
                rate_reg <= aup_pkg::RATE_RST;
                master_reg <= 1'b0;
            end else begin
                freq_reg <= freq_next;
                bcpf_reg <= bcpf_next;
                rate_reg <= rate_next;
                master_reg <= master_next;
            end
        end

        // read word of this port; zero unless one of its registers is addressed
        always_comb begin
            word = 32'h0000_0000;
            if (ctrl_hit[p]) begin
                word = {27'd0, freq_reg};
            end
            if (div_hit[p]) begin
                word = {19'd0, bcpf_reg};
            end
            if (mode_hit[p]) begin
                word[aup_pkg::RATE_W-1:0] = rate_reg;
                word[aup_pkg::MODE_MASTER_BIT] = master_reg;
                word[aup_pkg::MODE_ASYNC_BIT] = use_async[p];
                word[aup_pkg::MODE_FAM_BIT] = use_44k[p];
            end
        end

        assign port_word[p] = word;
        assign master_q[p] = master_reg;

        // a new code or family acts on the running phase, so the frame is not restarted
        aup_clk_gen u_gen (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .freq_sel(freq_reg),
            .fam_44k(use_44k[p]),
            .bcpf(bcpf_reg),
            .master(master_reg),
            .bclk(bclk[p]),
            .lrclk(lrclk[p])
        );
    end

    // the two family bits are shared by all ports: one per clock domain
    always_comb begin
        fam_next = fam_reg;
        if (wr_go && fam_hit) begin
            fam_next = pwdata[1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fam_reg <= 2'b00;
        end else begin
            fam_reg <= fam_next;
        end
    end

    // read mux: the indices are distinct, so at most one port word is non-zero
    always_comb begin
        rd_word = fam_hit ? {30'd0, fam_reg} : 32'h0000_0000;
        for (int p = 0; p < NP; p++) begin
            rd_word = rd_word | port_word[p];
        end
    end

    // ready: one wait state, then high for a single cycle
    always_comb begin
        ready_next = psel && penable && !ready_reg;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= ready_next;
        end
    end

    // read data stands with pready; writes and unmapped indices read as zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (!pwrite && any_hit) begin
            rdata_next = rd_word;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // the error flag rides in the same cycle as pready
    always_comb begin
        err_next = ready_next && !any_hit;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            err_reg <= 1'b0;
        end else begin
            err_reg <= err_next;
        end
    end

    assign prdata = rdata_reg;
    assign pready = ready_reg;
    assign pslverr = err_reg;
    assign clk_oe = master_q;
endmodule : aup_bclk_frame_gen

// ==== design/aup_clk_gen.sv ====
// per-port bit clock and frame clock generator
`timescale 1ns/1ps
module aup_clk_gen (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [4:0] freq_sel, // bit clock selector
    input wire logic fam_44k, // 44.1 kHz family in use
    input wire logic [12:0] bcpf, // bit clocks per frame
    input wire logic master, // generate clocks
    output logic bclk, // bit clock
    output logic lrclk // frame clock
);
    logic [31:0] step_tab48 [aup_pkg::NCODE];
    logic [31:0] step_tab44 [aup_pkg::NCODE];
    logic [31:0] step;
    logic [31:0] acc_reg, acc_next;
    logic [12:0] cnt_reg, cnt_next;
    logic bclk_reg, bclk_next, lr_reg, lr_next;
    logic [32:0] sum;
    logic [12:0] cnt_inc;

    for (genvar g = 0; g < aup_pkg::NCODE; g++) begin : g_tab
        localparam logic [31:0] S48 = aup_pkg::step_of(aup_pkg::FREQ48_HZ[g]);
        localparam logic [31:0] S44 = aup_pkg::step_of(aup_pkg::FREQ44_HZ[g]);
        assign step_tab48[g] = S48;
        assign step_tab44[g] = S44;
    end

    always_comb begin
        step = 32'h0000_0000;
        // codes 0x00, 0x01 and above 0x12 carry a zero step, so the clock stays parked
        if (freq_sel <= aup_pkg::FREQ_MAX) begin
            step = fam_44k ? step_tab44[freq_sel] : step_tab48[freq_sel];
        end
        sum = {1'b0, acc_reg} + {1'b0, step};
        cnt_inc = (cnt_reg + 13'd1 >= bcpf) ? 13'd0 : cnt_reg + 13'd1;
        acc_next = sum[31:0];
        bclk_next = bclk_reg;
        cnt_next = cnt_reg;
        lr_next = lr_reg;
        if (!master || step == 32'h0000_0000) begin
            acc_next = 32'h0000_0000;
            bclk_next = 1'b0;
            cnt_next = 13'd0;
            lr_next = 1'b0;
        end else if (sum[32]) begin
            bclk_next = ~bclk_reg;
            // frame clock moves on bit clock falling edges; high for the first half
            if (bclk_reg) begin
                cnt_next = cnt_inc;
                lr_next = (cnt_inc < (bcpf >> 1));
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= 32'h0000_0000;
            cnt_reg <= 13'd0;
            bclk_reg <= 1'b0;
            lr_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            cnt_reg <= cnt_next;
            bclk_reg <= bclk_next;
            lr_reg <= lr_next;
        end
    end

    assign bclk = bclk_reg;
    assign lrclk = lr_reg;
endmodule : aup_clk_gen

// ==== design/aup_pkg.sv ====
// shared constants for the audio port bit and frame clock generator
package aup_pkg;
    localparam int NPORT = 3;
    localparam longint CLK_HZ = 64'd100_000_000;
    localparam int IDXW = 14;
    localparam int NCODE = 19;
    localparam logic [4:0] FREQ_MAX = 5'h12;
    // register indices; the byte address is four times the index
    localparam logic [IDXW-1:0] IDX_CTRL [NPORT] = '{14'h0500, 14'h0540, 14'h0580};
    localparam logic [IDXW-1:0] IDX_DIV [NPORT] = '{14'h0506, 14'h0546, 14'h0586};
    localparam logic [IDXW-1:0] IDX_MODE [NPORT] = '{14'h050F, 14'h054F, 14'h058F};
    localparam logic [IDXW-1:0] IDX_FAMILY = 14'h0600;
    // fields and reset values
    localparam int FREQ_W = 5;
    localparam int BCPF_W = 13;
    localparam int RATE_W = 4;
    localparam int MODE_MASTER_BIT = 4;
    localparam int MODE_ASYNC_BIT = 8;
    localparam int MODE_FAM_BIT = 9;
    localparam int FAM_SYS_BIT = 0;
    localparam int FAM_ASYNC_BIT = 1;
    localparam logic [FREQ_W-1:0] FREQ_RST = 5'h0C;
    localparam logic [BCPF_W-1:0] BCPF_RST = 13'h0040;
    localparam logic [RATE_W-1:0] RATE_RST = 4'h0;
    localparam logic [RATE_W-1:0] RATE_ASYNC_MIN = 4'h8;
    // bit clock table in Hz, by selector code
    localparam longint FREQ48_HZ [NCODE] = '{0, 0, 64000, 96000, 128000, 192000, 256000,
        384000, 512000, 768000, 1024000, 1536000, 2048000, 3072000, 4096000, 6144000,
        8192000, 12288000, 24576000};
    localparam longint FREQ44_HZ [NCODE] = '{0, 0, 58800, 88200, 117600, 176400, 235200,
        352800, 470400, 705600, 940800, 1411200, 1881600, 2822400, 3763200, 5644800,
        7526400, 11289600, 22579200};

    // phase step that toggles the bit clock twice per period
    function automatic logic [31:0] step_of(input longint hz);
        longint s;
        s = (hz * 64'd2 * 64'h1_0000_0000) / CLK_HZ;
        return s[31:0];
    endfunction : step_of
endpackage : aup_pkg

// ==== verif/aup_audio_host.sv ====
// far-side host that times the frame clock of one port
`timescale 1ns/1ps
module aup_audio_host (
    input wire logic clk_sys, // sample clock
    input wire logic bclk, // bit clock
    input wire logic lrclk, // frame clock
    output logic [15:0] bits, // bits in last frame
    output logic [15:0] cycs // cycles in last frame
);
    logic b_q = 1'b0, l_q = 1'b0;
    logic [15:0] nb = 16'h0000, nc = 16'h0000;
    // slave role: listens only, the port masters both clocks
    always @(posedge clk_sys) begin
        b_q <= bclk;
        l_q <= lrclk;
        nb <= (lrclk && !l_q) ? 16'h0000 : nb + {15'h0000, bclk && !b_q};
        nc <= (lrclk && !l_q) ? 16'h0001 : nc + 16'h0001;
        if (lrclk && !l_q) {bits, cycs} <= {nb, nc};
    end
endmodule : aup_audio_host

// ==== verif/aup_bclk_frame_gen_chk.sv ====
// apb and port 0 clock assertions
`timescale 1ns/1ps
module aup_bclk_frame_gen_chk (
    input wire logic clk_sys, // clock
    input wire logic rst_n, // reset
    input wire logic psel, // select
    input wire logic penable, // enable
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic [2:0] bclk, // bit clocks
    input wire logic [2:0] lrclk, // frame clocks
    input wire logic [2:0] clk_oe // masters
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_wait; psel && penable && !pready |=> pready; endproperty
    property p_pulse; pready |=> !pready; endproperty
    property p_err; pslverr |-> pready; endproperty
    property p_rd0; pready && pslverr |-> prdata == 32'h0000_0000; endproperty
    property p_park; !clk_oe[0] && !$past(clk_oe[0]) |-> !bclk[0] && !lrclk[0]; endproperty
    property p_lr; clk_oe[0] && $past(clk_oe[0]) && $changed(lrclk[0]) |-> $fell(bclk[0]);
    endproperty
    // port 0 never runs above 6.144 MHz, so each half period spans at least eight cycles
    property p_hi; $rose(bclk[0]) |=> bclk[0] [*7]; endproperty
    property p_lo; $fell(bclk[0]) && clk_oe[0] |=> !bclk[0] [*7]; endproperty
    a_wait: assert property (p_wait) else $error("ready late");
    a_pulse: assert property (p_pulse) else $error("ready too long");
    a_err: assert property (p_err) else $error("error without ready");
    a_rd0: assert property (p_rd0) else $error("refused read not zero");
    a_park: assert property (p_park) else $error("clocks run as slave");
    a_lr: assert property (p_lr) else $error("frame edge off bit fall");
    a_hi: assert property (p_hi) else $error("bit clock high too short");
    a_lo: assert property (p_lo) else $error("bit clock low too short");
    c_err: cover property (pslverr);
    c_frm: cover property ($rose(lrclk[0]));
    c_fall: cover property (clk_oe[0] && $fell(lrclk[0]));
endmodule : aup_bclk_frame_gen_chk
bind aup_bclk_frame_gen aup_bclk_frame_gen_chk chk_inst (.clk_sys, .rst_n, .psel, .penable,
    .prdata, .pready, .pslverr, .bclk, .lrclk, .clk_oe);

// ==== verif/aup_bclk_frame_gen_tb.sv ====
// bench: registers over apb and frame timing on port 0
`timescale 1ns/1ps
module aup_bclk_frame_gen_tb;
    logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
    logic [15:0] paddr = 16'h0000, bits, cycs;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr;
    logic [2:0] bclk, lrclk, clk_oe;
    int num_errors = 0, compares = 0;
    always #5 clk_sys = ~clk_sys;
    aup_bclk_frame_gen aup_bclk_frame_gen_inst (.clk_sys, .rst_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .bclk, .lrclk, .clk_oe);
    aup_audio_host aup_audio_host_inst (.clk_sys, .bclk(bclk[0]), .lrclk(lrclk[0]), .bits, .cycs);
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    // on a read, d is the expected word
    task automatic apb(input logic w, input logic [13:0] i, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        e = pslverr;
        if (!w) chk("prdata", d, prdata);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // three frames, so the one cut short by reprogramming is skipped
    task automatic frm(input int lo, input int hi);
        repeat (3) @(posedge lrclk[0]);
        repeat (2) @(posedge clk_sys);
        chk("frame_bits", 32'h0000_0008, {16'h0000, bits});
        chk("frame_len", 32'h0000_0001, {31'h0, cycs >= lo && cycs <= hi});
    endtask : frm
    task automatic summarize();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    initial begin
        #200_000;
        num_errors++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int p = 0; p < 3; p++) begin
            apb(1'b0, aup_pkg::IDX_CTRL[p], 32'h0000_000C);
            apb(1'b0, aup_pkg::IDX_DIV[p], 32'h0000_0040);
            apb(1'b1, aup_pkg::IDX_DIV[p], 32'hFFFF_E008 + p);
            apb(1'b1, aup_pkg::IDX_CTRL[p], 32'h0000_0002 + 3 * p);
        end
        for (int p = 0; p < 3; p++) begin
            apb(1'b0, aup_pkg::IDX_DIV[p], 32'h0000_0008 + p);
            apb(1'b0, aup_pkg::IDX_CTRL[p], 32'h0000_0002 + 3 * p);
        end
        apb(1'b0, 14'h0001, 32'h0000_0000);
        chk("pslverr", 32'h0000_0001, {31'h0, e});
        apb(1'b1, aup_pkg::IDX_CTRL[0], 32'h0000_000F);
        apb(1'b1, aup_pkg::IDX_MODE[0], 32'h0000_0010);
        frm(129, 131);
        chk("clk_oe", 32'h0000_0001, {29'h0, clk_oe});
        apb(1'b1, aup_pkg::IDX_FAMILY, 32'h0000_0001);
        frm(141, 143);
        apb(1'b0, aup_pkg::IDX_MODE[0], 32'h0000_0210);
        apb(1'b1, aup_pkg::IDX_MODE[0], 32'h0000_0018);
        frm(129, 131);
        apb(1'b0, aup_pkg::IDX_MODE[0], 32'h0000_0118);
        apb(1'b1, aup_pkg::IDX_CTRL[1], 32'h0000_0001);
        apb(1'b1, aup_pkg::IDX_MODE[1], 32'h0000_0010);
        apb(1'b1, aup_pkg::IDX_CTRL[2], 32'h0000_0013);
        apb(1'b1, aup_pkg::IDX_MODE[2], 32'h0000_0010);
        repeat (100) @(posedge clk_sys);
        chk("bclk1", 32'h0000_0000, {31'h0, bclk[1]});
        chk("parked", 32'h0000_0000, {29'h0, bclk[2], lrclk[2:1]});
        chk("clk_oe", 32'h0000_0007, {29'h0, clk_oe});
        summarize();
    end
endmodule : aup_bclk_frame_gen_tb
